// *** core/hccr_regs.sv ***
// Functional notes
// - feature bit 4 enables four link status outputs
// - delay field used only when fused delay zero
// - power re-enable wait is field times 200 ms
// - feature bit 0 switches PLL spread spectrum off
// - feature byte loadable by EEPROM in I2C or SMBus mode only, SMBus overwrites
// - status bits 7:2 read zero, writes ignored
// - reload command restores reset values, flag to one
// - reload command accepted only in SMBus mode
// - reload bit self-clears; writing zero does nothing
// - config flag set on entering I2C or SMBus mode
// - no upstream attach while config flag is one
// - I2C mode exit clears config flag
// - writing one clears config flag; zero ignored
// - text buffer 0x100-0x2df is write only
// - built-in default text replaced by buffer writes
module hccr_regs
  import hccr_pkg::*;
#(
  parameter int UNIT_CYCLES = HCCR_DELAY_UNIT_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // configuration port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic reg_src_smbus_i,
  input wire logic [9:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // configuration modes
  input wire logic i2c_mode_i,
  input wire logic smbus_mode_i,
  // link status from hub core
  input wire logic highspeed_link_up_i,
  input wire logic highspeed_suspended_i,
  input wire logic superspeed_link_up_i,
  input wire logic superspeed_suspended_i,
  output logic highspeed_link_up_out_o,
  output logic highspeed_suspended_out_o,
  output logic superspeed_link_up_out_o,
  output logic superspeed_suspended_out_o,
  output logic link_status_pins_oe_o,
  // battery charging power sequencing
  input wire logic [2:0] fused_power_restore_delay_i,
  input wire logic bc_mode_change_i,
  input wire logic port_power_request_i,
  output logic port_power_switch_control_o,
  output logic power_reenable_wait_o,
  // phy and upstream
  output logic pll_spread_spectrum_off_o,
  output logic upstream_connect_allow_o,
  // text read port for the billboard function
  input wire logic text_rd_i,
  input wire logic [HCCR_TEXT_AW-1:0] text_rd_addr_i,
  output logic [7:0] billboard_text_bytes_o
);

  logic [7:0] feature_r;
  logic configuration_in_progress_r;
  logic register_reload_command_r;
  logic text_loaded_r;
  logic i2c_mode_prev_r;
  logic smbus_mode_prev_r;
  logic [7:0] rdata_r;
  logic rvalid_r;
  logic [3:0] status_r;
  hccr_pwr_state_t pwr_state_r;
  logic [31:0] unit_cnt_r;
  logic [2:0] mult_cnt_r;
  logic text_rd_dflt_r;
  logic [7:0] dflt_byte_r;
  logic [7:0] mem_rd_data;

  logic wr_ok;
  logic wr_feature;
  logic wr_status;
  logic wr_text;
  logic rd_text;
  logic reload_req;
  logic cfg_set;
  logic cfg_clr;
  logic [2:0] delay_sel;
  logic [HCCR_TEXT_AW-1:0] text_wr_addr;
  logic [9:0] text_off;

  // built-in default text, UTF-16LE, repeating pattern
  function automatic logic [7:0] hccr_dflt_char(input logic [HCCR_TEXT_AW-1:0] idx);
    logic [3:0] ch;
    ch = idx[4:1];
    if (idx[0]) begin
      return 8'h00;
    end
    case (ch)
      4'h0: return 8'h42;
      4'h1: return 8'h69;
      4'h2: return 8'h6c;
      4'h3: return 8'h6c;
      4'h4: return 8'h62;
      4'h5: return 8'h6f;
      4'h6: return 8'h61;
      4'h7: return 8'h72;
      4'h8: return 8'h64;
      default: return 8'h20;
    endcase
  endfunction : hccr_dflt_char

  // access decode
  assign wr_ok = reg_wr_i && (reg_src_smbus_i || i2c_mode_i || smbus_mode_i);
  assign wr_feature = wr_ok && (reg_addr_i == HCCR_FEATURE_OFFSET);
  assign wr_status = wr_ok && (reg_addr_i == HCCR_STATUS_OFFSET);
  assign wr_text = wr_ok && (reg_addr_i >= HCCR_TEXT_FIRST) && (reg_addr_i <= HCCR_TEXT_LAST);
  assign rd_text = reg_rd_i && (reg_addr_i >= HCCR_TEXT_FIRST) && (reg_addr_i <= HCCR_TEXT_LAST);
  assign text_off = reg_addr_i - HCCR_TEXT_FIRST;
  assign text_wr_addr = text_off[HCCR_TEXT_AW-1:0];
  assign reload_req = wr_status && reg_wdata_i[HCCR_STAT_RELOAD_BIT] && smbus_mode_i;
  assign cfg_set = (i2c_mode_i && !i2c_mode_prev_r) || (smbus_mode_i && !smbus_mode_prev_r);
  assign cfg_clr = (wr_status && reg_wdata_i[HCCR_STAT_CFG_ACTIVE_BIT])
                   || (!i2c_mode_i && i2c_mode_prev_r);

  // mode edge tracking
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      i2c_mode_prev_r <= 1'b0;
      smbus_mode_prev_r <= 1'b0;
    end else if (ce_i) begin
      i2c_mode_prev_r <= i2c_mode_i;
      smbus_mode_prev_r <= smbus_mode_i;
    end
  end

  // feature byte, full byte stored as written
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      feature_r <= HCCR_FEATURE_RESET;
    end else if (ce_i) begin
      if (register_reload_command_r) begin
        feature_r <= HCCR_FEATURE_RESET;
      end else if (wr_feature) begin
        feature_r <= reg_wdata_i;
      end
    end
  end

  // reload command, one cycle pending then self-clear
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      register_reload_command_r <= 1'b0;
    end else if (ce_i) begin
      if (register_reload_command_r) begin
        register_reload_command_r <= 1'b0;
      end else if (reload_req) begin
        register_reload_command_r <= 1'b1;
      end
    end
  end

  // configuration flag, set beats clear
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      configuration_in_progress_r <= HCCR_CFG_ACTIVE_RESET;
    end else if (ce_i) begin
      if (register_reload_command_r) begin
        configuration_in_progress_r <= HCCR_CFG_ACTIVE_RELOAD;
      end else if (cfg_set) begin
        configuration_in_progress_r <= 1'b1;
      end else if (cfg_clr) begin
        configuration_in_progress_r <= 1'b0;
      end
    end
  end

  // default text selector
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      text_loaded_r <= 1'b0;
    end else if (ce_i) begin
      if (register_reload_command_r) begin
        text_loaded_r <= 1'b0;
      end else if (wr_text) begin
        text_loaded_r <= 1'b1;
      end
    end
  end

  hccr_text_mem u_text_mem (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .wr_en_i(wr_text),
    .wr_addr_i(text_wr_addr),
    .wr_data_i(reg_wdata_i),
    .rd_en_i(text_rd_i),
    .rd_addr_i(text_rd_addr_i),
    .rd_data_o(mem_rd_data)
  );

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      text_rd_dflt_r <= 1'b1;
      dflt_byte_r <= 8'h00;
    end else if (ce_i && text_rd_i) begin
      text_rd_dflt_r <= !text_loaded_r;
      dflt_byte_r <= hccr_dflt_char(text_rd_addr_i);
    end
  end

  assign billboard_text_bytes_o = text_rd_dflt_r ? dflt_byte_r : mem_rd_data;

  // register read path
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else if (ce_i) begin
      rvalid_r <= reg_rd_i;
      if (reg_rd_i) begin
        if (reg_addr_i == HCCR_FEATURE_OFFSET) begin
          rdata_r <= feature_r;
        end else if (reg_addr_i == HCCR_STATUS_OFFSET) begin
          rdata_r <= {6'h00, register_reload_command_r, configuration_in_progress_r};
        end else begin
          rdata_r <= 8'h00;
        end
      end
    end
  end

  assign reg_rdata_o = rdata_r;
  assign reg_rvalid_o = rvalid_r;

  // status outputs registered, enable gates the drivers
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      status_r <= 4'h0;
    end else if (ce_i) begin
      status_r <= {highspeed_link_up_i, highspeed_suspended_i,
                   superspeed_link_up_i, superspeed_suspended_i};
    end
  end

  assign link_status_pins_oe_o = feature_r[HCCR_FEAT_STS_EN_BIT];
  assign highspeed_link_up_out_o = link_status_pins_oe_o & status_r[3];
  assign highspeed_suspended_out_o = link_status_pins_oe_o & status_r[2];
  assign superspeed_link_up_out_o = link_status_pins_oe_o & status_r[1];
  assign superspeed_suspended_out_o = link_status_pins_oe_o & status_r[0];

  assign pll_spread_spectrum_off_o = feature_r[HCCR_FEAT_SPREAD_OFF_BIT];
  assign upstream_connect_allow_o = !configuration_in_progress_r;

  // power re-enable sequencing
  assign delay_sel = (fused_power_restore_delay_i == 3'h0) ?
                     feature_r[HCCR_FEAT_DELAY_MSB:HCCR_FEAT_DELAY_LSB] :
                     fused_power_restore_delay_i;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pwr_state_r <= HCCR_PWR_ON;
      unit_cnt_r <= 32'h0;
      mult_cnt_r <= 3'h0;
    end else if (ce_i) begin
      case (pwr_state_r)
        HCCR_PWR_ON: begin
          if (bc_mode_change_i) begin
            pwr_state_r <= HCCR_PWR_WAIT;
            mult_cnt_r <= delay_sel;
            unit_cnt_r <= 32'(UNIT_CYCLES - 1);
          end
        end
        HCCR_PWR_WAIT: begin
          if (mult_cnt_r == 3'h0) begin
            pwr_state_r <= HCCR_PWR_ON;
          end else if (unit_cnt_r == 32'h0) begin
            mult_cnt_r <= mult_cnt_r - 3'h1;
            unit_cnt_r <= 32'(UNIT_CYCLES - 1);
          end else begin
            unit_cnt_r <= unit_cnt_r - 32'h1;
          end
        end
        default: begin
          pwr_state_r <= HCCR_PWR_ON;
        end
      endcase
    end
  end

  assign power_reenable_wait_o = (pwr_state_r == HCCR_PWR_WAIT);
  assign port_power_switch_control_o = port_power_request_i && !power_reenable_wait_o;

  // checks
  a_status_pin_gate: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && wr_feature && !register_reload_command_r |=>
      link_status_pins_oe_o == $past(reg_wdata_i[HCCR_FEAT_STS_EN_BIT]))
    else $error("status output enable does not follow feature bit");

  a_spread_off_bit: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && wr_feature && !register_reload_command_r |=>
      pll_spread_spectrum_off_o == $past(reg_wdata_i[HCCR_FEAT_SPREAD_OFF_BIT]))
    else $error("spread spectrum control does not follow feature bit");

  a_power_off_wait: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && pwr_state_r == HCCR_PWR_ON && bc_mode_change_i && delay_sel != 3'h0 |=>
      !port_power_switch_control_o && mult_cnt_r == $past(delay_sel))
    else $error("power switch not held off with selected delay");

  a_power_wait_step: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && pwr_state_r == HCCR_PWR_WAIT && mult_cnt_r != 3'h0 && unit_cnt_r == 32'h0 |=>
      unit_cnt_r == 32'(UNIT_CYCLES - 1) && mult_cnt_r == $past(mult_cnt_r) - 3'h1)
    else $error("delay unit count not reloaded");

  a_upstream_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && (cfg_set || register_reload_command_r) |=> !upstream_connect_allow_o)
    else $error("upstream connect allowed during configuration");

  a_reload_smbus_only: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && !smbus_mode_i && !register_reload_command_r |=> !register_reload_command_r)
    else $error("reload accepted outside SMBus mode");

  a_reload_restores: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && register_reload_command_r |=>
      configuration_in_progress_r && feature_r == HCCR_FEATURE_RESET && !text_loaded_r)
    else $error("reload did not restore reset values");

  a_reload_selfclear: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && register_reload_command_r |=> !register_reload_command_r)
    else $error("reload bit did not self-clear");

  a_cfg_clear_one: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && cfg_clr && !cfg_set && !register_reload_command_r |=>
      !configuration_in_progress_r)
    else $error("config flag not cleared");

  a_cfg_set_entry: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && cfg_set |=> configuration_in_progress_r)
    else $error("config flag not set on mode entry");

  a_text_unreadable: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && rd_text |=> reg_rvalid_o && reg_rdata_o == 8'h00)
    else $error("text buffer returned data");

  a_status_reserved: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && reg_rd_i && reg_addr_i == HCCR_STATUS_OFFSET |=> reg_rdata_o[7:2] == 6'h00)
    else $error("status reserved bits nonzero");

  a_idle_wr_ignored: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && reg_wr_i && !reg_src_smbus_i && !i2c_mode_i && !smbus_mode_i
      && !register_reload_command_r |=> $stable(feature_r))
    else $error("idle write changed feature byte");

endmodule : hccr_regs

// *** core/hccr_pkg.sv ***
package hccr_pkg;

  // register map, byte offsets on the configuration port
  localparam logic [9:0] HCCR_FEATURE_OFFSET = 10'h0f0;
  localparam logic [9:0] HCCR_STATUS_OFFSET = 10'h0f8;
  localparam logic [9:0] HCCR_TEXT_FIRST = 10'h100;
  localparam logic [9:0] HCCR_TEXT_LAST = 10'h2df;
  localparam int HCCR_TEXT_DEPTH = 480;
  localparam int HCCR_TEXT_AW = 9;

  // additional_feature_config fields
  localparam int HCCR_FEAT_STS_EN_BIT = 4;
  localparam int HCCR_FEAT_DELAY_LSB = 1;
  localparam int HCCR_FEAT_DELAY_MSB = 3;
  localparam int HCCR_FEAT_SPREAD_OFF_BIT = 0;
  localparam logic [7:0] HCCR_FEATURE_RESET = 8'h00;

  // config_status_command fields
  localparam int HCCR_STAT_RELOAD_BIT = 1;
  localparam int HCCR_STAT_CFG_ACTIVE_BIT = 0;
  localparam logic HCCR_CFG_ACTIVE_RESET = 1'b0;
  localparam logic HCCR_CFG_ACTIVE_RELOAD = 1'b1;

  // power re-enable wait unit
  localparam int HCCR_DELAY_UNIT_MS = 200;
  localparam int HCCR_CLK_KHZ = 250000;
  localparam int HCCR_DELAY_UNIT_CYCLES = HCCR_DELAY_UNIT_MS * HCCR_CLK_KHZ;

  typedef enum logic [1:0] {
    HCCR_PWR_ON = 2'b00,
    HCCR_PWR_WAIT = 2'b01
  } hccr_pwr_state_t;

endpackage : hccr_pkg

// *** core/hccr_text_mem.sv ***
module hccr_text_mem
  import hccr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic wr_en_i,
  input wire logic [HCCR_TEXT_AW-1:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic rd_en_i,
  input wire logic [HCCR_TEXT_AW-1:0] rd_addr_i,
  output logic [7:0] rd_data_o
);

  logic [7:0] mem_r [HCCR_TEXT_DEPTH];

  always_ff @(posedge clk_i) begin
    if (ce_i && wr_en_i) begin
      mem_r[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rd_data_o <= 8'h00;
    end else if (ce_i && rd_en_i) begin
      rd_data_o <= mem_r[rd_addr_i];
    end
  end

endmodule : hccr_text_mem

// *** bench/hccr_host_model.sv ***
module hccr_host_model
  import hccr_pkg::*;
(
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i,
  output logic wr_o,
  output logic rd_o,
  output logic src_o,
  output logic [9:0] addr_o,
  output logic [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    src_o = 1'b0;
    addr_o = 10'h000;
    wdata_o = 8'h00;
  end

  // one strobe cycle, then released lines show the inverse
  task automatic put(input logic [9:0] a, input logic [7:0] d, input logic s, input logic w);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= (a == HCCR_FEATURE_OFFSET) ? (d & 8'h1f) : d;
    src_o <= s;
    wr_o <= w;
    rd_o <= ~w;
    @(posedge clk_i);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
    src_o <= ~s;
  endtask : put

  task automatic write_byte(input logic [9:0] a, input logic [7:0] d, input logic s);
    put(a, d, s, 1'b1);
  endtask : write_byte

  task automatic read_byte(input logic [9:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    put(a, 8'h00, 1'b1, 1'b0);
    #1;
    if (rvalid_i === 1'b1) begin
      ok = 1'b1;
      d = rdata_i;
    end
  endtask : read_byte
endmodule : hccr_host_model

// *** bench/tb.sv ***
module tb
  import hccr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic wr, rd, src, rvalid, i2c = 1'b0, smb = 1'b0, bc = 1'b0, preq = 1'b1, trd = 1'b0;
  logic [9:0] addr;
  logic [7:0] wdata, rdata, tout, v;
  logic [3:0] lin = 4'h0, lout;
  logic [2:0] fused = 3'h0;
  logic [8:0] taddr = 9'h000;
  logic oe, sw, pwait, spread, allow;
  logic ce = 1'b1;
  int err_count = 0;
  int total_checks = 0;

  always #2 clk = ~clk;

  hccr_host_model host (.clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid), .wr_o(wr), .rd_o(rd),
    .src_o(src), .addr_o(addr), .wdata_o(wdata));

  hccr_regs #(.UNIT_CYCLES(8)) dut (.clk_i(clk), .rst_b_i(rst_b), .ce_i(ce),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_src_smbus_i(src), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .i2c_mode_i(i2c),
    .smbus_mode_i(smb), .highspeed_link_up_i(lin[3]), .highspeed_suspended_i(lin[2]),
    .superspeed_link_up_i(lin[1]), .superspeed_suspended_i(lin[0]),
    .highspeed_link_up_out_o(lout[3]), .highspeed_suspended_out_o(lout[2]),
    .superspeed_link_up_out_o(lout[1]), .superspeed_suspended_out_o(lout[0]),
    .link_status_pins_oe_o(oe), .fused_power_restore_delay_i(fused),
    .bc_mode_change_i(bc), .port_power_request_i(preq),
    .port_power_switch_control_o(sw), .power_reenable_wait_o(pwait),
    .pll_spread_spectrum_off_o(spread), .upstream_connect_allow_o(allow),
    .text_rd_i(trd), .text_rd_addr_i(taddr), .billboard_text_bytes_o(tout));

  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic rd_reg(input logic [9:0] a, output logic [7:0] d);
    logic ok;
    host.read_byte(a, d, ok);
    chk("rvalid", {7'h00, ok}, 8'h01);
  endtask : rd_reg

  task automatic rd_text(input logic [8:0] a, output logic [7:0] d);
    @(posedge clk);
    trd <= 1'b1;
    taddr <= a;
    @(posedge clk);
    trd <= 1'b0;
    taddr <= ~a;
    #1;
    d = tout;
  endtask : rd_text

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // measures the length of one power re-enable wait
  task automatic pwr_wait(input int exp);
    int cnt;
    int bad;
    cnt = 0;
    bad = 0;
    @(posedge clk);
    bc <= 1'b1;
    @(posedge clk);
    bc <= 1'b0;
    for (int i = 0; i < 200; i++) begin
      @(posedge clk);
      #1;
      if (pwait === 1'b1) begin
        cnt++;
        if (sw !== 1'b0) bad++;
      end else if (cnt > 0) begin
        break;
      end
    end
    chk("wait length", {7'h00, cnt >= exp - 1 && cnt <= exp + 1}, 8'h01);
    chk("switch off in wait", bad[7:0], 8'h00);
    chk("switch after wait", {7'h00, sw}, 8'h01);
  endtask : pwr_wait

  initial begin
    step(4);
    rst_b <= 1'b1;
    step(1);
    rd_reg(HCCR_FEATURE_OFFSET, v);
    chk("feature reset", v, HCCR_FEATURE_RESET);
    rd_reg(HCCR_STATUS_OFFSET, v);
    chk("status reset", v, 8'h00);
    chk("allow reset", {7'h00, allow}, 8'h01);
    host.write_byte(HCCR_FEATURE_OFFSET, 8'h11, 1'b0);
    rd_reg(HCCR_FEATURE_OFFSET, v);
    chk("no mode eeprom write", v, 8'h00);
    smb <= 1'b1;
    step(2);
    rd_reg(HCCR_STATUS_OFFSET, v);
    chk("flag on smbus entry", v, 8'h01);
    chk("no attach", {7'h00, allow}, 8'h00);
    lin <= 4'ha;
    host.write_byte(HCCR_FEATURE_OFFSET, 8'h11, 1'b1);
    step(2);
    chk("status outs", {4'h0, lout}, 8'h0a);
    chk("status oe", {7'h00, oe}, 8'h01);
    chk("spread off", {7'h00, spread}, 8'h01);
    host.write_byte(HCCR_STATUS_OFFSET, 8'hfc, 1'b1);
    rd_reg(HCCR_STATUS_OFFSET, v);
    chk("reserved and zero write", v, 8'h01);
    host.write_byte(HCCR_STATUS_OFFSET, 8'h01, 1'b1);
    rd_reg(HCCR_STATUS_OFFSET, v);
    chk("flag cleared", v, 8'h00);
    chk("attach allowed", {7'h00, allow}, 8'h01);
    smb <= 1'b0;
    i2c <= 1'b1;
    step(2);
    rd_reg(HCCR_STATUS_OFFSET, v);
    chk("flag on i2c entry", v, 8'h01);
    host.write_byte(HCCR_FEATURE_OFFSET, 8'h06, 1'b0);
    step(2);
    rd_reg(HCCR_FEATURE_OFFSET, v);
    chk("eeprom load", v, 8'h06);
    chk("status disabled", {3'h0, oe, lout}, 8'h00);
    chk("spread on", {7'h00, spread}, 8'h00);
    host.write_byte(HCCR_STATUS_OFFSET, 8'h02, 1'b1);
    step(2);
    rd_reg(HCCR_FEATURE_OFFSET, v);
    chk("reload refused", v, 8'h06);
    i2c <= 1'b0;
    step(2);
    rd_reg(HCCR_STATUS_OFFSET, v);
    chk("i2c exit clears", v, 8'h00);
    pwr_wait(3 * 8 + 1);
    fused <= 3'h2;
    pwr_wait(2 * 8 + 1);
    fused <= 3'h0;
    host.write_byte(HCCR_TEXT_FIRST, 8'h5a, 1'b1);
    host.write_byte(HCCR_TEXT_LAST, 8'ha5, 1'b1);
    rd_text(9'h000, v);
    chk("text first", v, 8'h5a);
    rd_text(9'(HCCR_TEXT_DEPTH - 1), v);
    chk("text last", v, 8'ha5);
    rd_reg(HCCR_TEXT_LAST, v);
    chk("text write only", v, 8'h00);
    rd_reg(10'h3ff, v);
    chk("unmapped", v, 8'h00);
    smb <= 1'b1;
    step(2);
    host.write_byte(HCCR_STATUS_OFFSET, 8'h01, 1'b1);
    host.write_byte(HCCR_STATUS_OFFSET, 8'h02, 1'b1);
    step(3);
    rd_reg(HCCR_FEATURE_OFFSET, v);
    chk("reload feature", v, HCCR_FEATURE_RESET);
    rd_reg(HCCR_STATUS_OFFSET, v);
    chk("reload self clear flag set", v, 8'h01);
    host.write_byte(HCCR_FEATURE_OFFSET, 8'h10, 1'b1);
    rd_reg(HCCR_FEATURE_OFFSET, v);
    chk("reprogram", v, 8'h10);
    ce <= 1'b0;
    host.write_byte(HCCR_FEATURE_OFFSET, 8'h01, 1'b1);
    ce <= 1'b1;
    rd_reg(HCCR_FEATURE_OFFSET, v);
    chk("frozen by enable", v, 8'h10);
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    wrap_up();
  end
endmodule : tb
